/* File: verilog/cbt_top.v */
// acceptance filtering into two receive buffers plus bit timing
// assumes message arrival from receive logic as a one-cycle strobe
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "cbt_defs.vh"

// Notes on behaviour
// - a complete message in the assembly buffer moves to a buffer only on filter match
// - mask bit clear makes that identifier position match regardless
// - mask bit set needs filter bit equal to identifier bit
// - filters 0,1 with mask 0 feed buffer 0; filters 2-5 with mask 1 feed buffer 1
// - one quantum is 2*(prescaler+1) clock periods
// - bit time is quantum times quanta per bit, 5 to 25; below 8 unreliable
// - each bit opens with a one-quantum sync segment
// - propagation segment lasts 1 to 8 quanta from its 3-bit field
// - phase segment 1 lasts 1 to 8 quanta; its end is the sample point
// - phase segment 2 is 1 to 8 quanta but at least two
// - resync lengthens phase 1 or shortens phase 2 on falling bus edges
// - received bit is fixed at the end of phase segment 1
// - triple sampling takes majority of three samples half a quantum apart
// - processing time after the sample point is two quanta
// - assembly buffer always takes the next message and is not readable
module cbt_top #(
  parameter ID_W  = 29,
  parameter PRE_W = 6,
  parameter NFILT = 6
) (
  input  wire        REF_CLK_I,
  input  wire        RST_N_I,
  input  wire [7:0]  ADDR_I,
  input  wire [31:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [31:0] RDATA_O,
  input  wire        CAN_RX_I,
  input  wire        MSG_VALID_I,
  input  wire [28:0] MSG_ID_I,
  input  wire        MSG_EXT_I,
  input  wire [3:0]  MSG_DLC_I,
  input  wire [63:0] MSG_DATA_I,
  output wire        RX_BIT_O,
  output wire        SAMPLE_O,
  output wire        BIT_START_O,
  output reg         ACCEPT0_O,
  output reg         ACCEPT1_O
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [31:0]     timing_q;
  reg [ID_W:0]   filt_q [0:NFILT-1];
  reg [ID_W-1:0] mask_q [0:1];

  reg [ID_W-1:0] asm_id_q;
  reg            asm_ext_q;
  reg [3:0]      asm_dlc_q;
  reg [63:0]     asm_data_q;
  reg            asm_pend_q;

  reg [ID_W-1:0] rxb_id_q   [0:1];
  reg            rxb_ext_q  [0:1];
  reg [3:0]      rxb_dlc_q  [0:1];
  reg [63:0]     rxb_data_q [0:1];
  reg [1:0]      full_q;
  reg [1:0]      ovf_q;
  reg [2:0]      hit_q;

  localparam NBUF = 2;

  integer i_hit;
  integer i_wr;
  integer i_buf;
  integer i_rd;

  // ----------------------------------------------------------------
  // filter compare
  // ----------------------------------------------------------------
  function id_match;
    input [ID_W-1:0] id;
    input            ext;
    input [ID_W:0]   filt;
    input [ID_W-1:0] mask;
    reg   [ID_W-1:0] width_mask;
    begin
      width_mask = ext ? {ID_W{1'b1}} :
                   {{(ID_W-`CBT_STD_ID_W){1'b0}}, {`CBT_STD_ID_W{1'b1}}};
      id_match = (ext == filt[ID_W]) &&
                 (((id ^ filt[ID_W-1:0]) & mask & width_mask) == {ID_W{1'b0}});
    end
  endfunction

  function filt_addr;
    input [7:0]   addr;
    input integer idx;
    begin
      filt_addr = (addr == `CBT_ADDR_FILT0 + 8'h04 * idx[7:0]);
    end
  endfunction

  wire [NFILT-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < NFILT; g = g + 1) begin : g_filt
      assign hit[g] = id_match(asm_id_q, asm_ext_q, filt_q[g],
                               mask_q[(g < 2) ? 0 : 1]);
    end
  endgenerate

  wire acc0 = asm_pend_q & (|hit[1:0]);
  wire acc1 = asm_pend_q & ~acc0 & (|hit[NFILT-1:2]);

  // ----------------------------------------------------------------
  // lowest matching filter index
  // ----------------------------------------------------------------
  reg [2:0] hit_idx;
  always @* begin
    hit_idx = 3'h0;
    for (i_hit = NFILT - 1; i_hit >= 0; i_hit = i_hit - 1) begin
      if (hit[i_hit]) begin
        hit_idx = i_hit[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire       wr_status = WR_I && (ADDR_I == `CBT_ADDR_STATUS);
  wire [1:0] clr_full  = wr_status ? WDATA_I[`CBT_ST_FULL1:`CBT_ST_FULL0] : 2'h0;
  wire [1:0] clr_ovf   = wr_status ? WDATA_I[`CBT_ST_OVF1:`CBT_ST_OVF0] : 2'h0;
  wire [1:0] acc       = {acc1, acc0};
  wire [1:0] store     = acc & ~full_q;
  wire [1:0] ovf_set   = acc & full_q;

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      timing_q <= `CBT_TIM_RESET;
      for (i_wr = 0; i_wr < NFILT; i_wr = i_wr + 1) begin
        filt_q[i_wr] <= {(ID_W+1){1'b0}};
      end
      mask_q[0] <= {ID_W{1'b0}};
      mask_q[1] <= {ID_W{1'b0}};
    end else if (WR_I) begin
      if (ADDR_I == `CBT_ADDR_TIMING) begin
        timing_q <= {14'h0000, WDATA_I[17:0]};
      end
      for (i_wr = 0; i_wr < NFILT; i_wr = i_wr + 1) begin
        if (filt_addr(ADDR_I, i_wr)) begin
          filt_q[i_wr] <= {WDATA_I[`CBT_FILT_EXT], WDATA_I[ID_W-1:0]};
        end
      end
      if (ADDR_I == `CBT_ADDR_MASK0) begin
        mask_q[0] <= WDATA_I[ID_W-1:0];
      end
      if (ADDR_I == `CBT_ADDR_MASK1) begin
        mask_q[1] <= WDATA_I[ID_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // assembly buffer: always open for the next message
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      asm_id_q   <= {ID_W{1'b0}};
      asm_ext_q  <= 1'b0;
      asm_dlc_q  <= 4'h0;
      asm_data_q <= 64'h0000_0000_0000_0000;
      asm_pend_q <= 1'b0;
    end else begin
      asm_pend_q <= MSG_VALID_I;
      if (MSG_VALID_I) begin
        asm_id_q   <= MSG_ID_I[ID_W-1:0];
        asm_ext_q  <= MSG_EXT_I;
        asm_dlc_q  <= MSG_DLC_I;
        asm_data_q <= MSG_DATA_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffers and accept pulses
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (i_buf = 0; i_buf < NBUF; i_buf = i_buf + 1) begin
        rxb_id_q[i_buf]   <= {ID_W{1'b0}};
        rxb_ext_q[i_buf]  <= 1'b0;
        rxb_dlc_q[i_buf]  <= 4'h0;
        rxb_data_q[i_buf] <= 64'h0000_0000_0000_0000;
      end
      hit_q     <= 3'h0;
      ACCEPT0_O <= 1'b0;
      ACCEPT1_O <= 1'b0;
    end else begin
      for (i_buf = 0; i_buf < NBUF; i_buf = i_buf + 1) begin
        if (store[i_buf]) begin
          rxb_id_q[i_buf]   <= asm_id_q;
          rxb_ext_q[i_buf]  <= asm_ext_q;
          rxb_dlc_q[i_buf]  <= asm_dlc_q;
          rxb_data_q[i_buf] <= asm_data_q;
        end
      end
      ACCEPT0_O <= store[0];
      ACCEPT1_O <= store[1];
      if (|store) begin
        hit_q <= hit_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags: a set wins over a clear
  // ----------------------------------------------------------------
  wire [1:0] full_d = (full_q & ~clr_full) | store;
  wire [1:0] ovf_d  = (ovf_q & ~clr_ovf) | ovf_set;

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      full_q <= 2'h0;
      ovf_q  <= 2'h0;
    end else begin
      full_q <= full_d;
      ovf_q  <= ovf_d;
    end
  end

  // ----------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  function [31:0] rxb_word;
    input [1:0] sel;
    input       b;
    begin
      case (sel)
        2'h0:    rxb_word = {1'b0, rxb_ext_q[b], {(30-ID_W){1'b0}}, rxb_id_q[b]};
        2'h1:    rxb_word = {28'h0000000, rxb_dlc_q[b]};
        2'h2:    rxb_word = rxb_data_q[b][31:0];
        default: rxb_word = rxb_data_q[b][63:32];
      endcase
    end
  endfunction

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (ADDR_I == `CBT_ADDR_TIMING) begin
      rd_d = timing_q;
    end else if (ADDR_I == `CBT_ADDR_STATUS) begin
      rd_d = {24'h000000, hit_q, RX_BIT_O, ovf_q, full_q};
    end else if (ADDR_I == `CBT_ADDR_MASK0) begin
      rd_d = {{(32-ID_W){1'b0}}, mask_q[0]};
    end else if (ADDR_I == `CBT_ADDR_MASK1) begin
      rd_d = {{(32-ID_W){1'b0}}, mask_q[1]};
    end else if (ADDR_I[7:4] == `CBT_ADDR_RX_BUFFER_0 >> 4 && ADDR_I[3] == 1'b1) begin
      rd_d = rxb_word({1'b0, ADDR_I[2]}, 1'b0);
    end else if (ADDR_I[7:4] == 4'h3 && ADDR_I[3] == 1'b0) begin
      rd_d = rxb_word({1'b1, ADDR_I[2]}, 1'b0);
    end else if (ADDR_I >= `CBT_ADDR_RX_BUFFER_1 && ADDR_I < `CBT_ADDR_RX_BUFFER_1 + 8'h10) begin
      rd_d = rxb_word(ADDR_I[3:2] - 2'h2, 1'b1);
    end else begin
      for (i_rd = 0; i_rd < NFILT; i_rd = i_rd + 1) begin
        if (filt_addr(ADDR_I, i_rd)) begin
          rd_d = {1'b0, filt_q[i_rd][ID_W], {(30-ID_W){1'b0}}, filt_q[i_rd][ID_W-1:0]};
        end
      end
    end
  end

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= rd_d;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  cbt_bit_timing #(
    .PRE_W (PRE_W)
  ) u_timing (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RST_N_I),
    .prescaler_i (timing_q[`CBT_TIM_PRE_MSB:`CBT_TIM_PRE_LSB]),
    .prop_i      (timing_q[`CBT_TIM_PROP_MSB:`CBT_TIM_PROP_LSB]),
    .ps1_i       (timing_q[`CBT_TIM_PS1_MSB:`CBT_TIM_PS1_LSB]),
    .ps2_i       (timing_q[`CBT_TIM_PS2_MSB:`CBT_TIM_PS2_LSB]),
    .sjw_i       (timing_q[`CBT_TIM_SJW_MSB:`CBT_TIM_SJW_LSB]),
    .triple_i    (timing_q[`CBT_TIM_TRIPLE]),
    .bus_i       (CAN_RX_I),
    .rx_bit_o    (RX_BIT_O),
    .sample_o    (SAMPLE_O),
    .bit_start_o (BIT_START_O)
  );

endmodule

/* File: verilog/cbt_defs.vh */
// constants of the acceptance filter and bit timing block
// assumes 32-bit register port with word-aligned byte addresses
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CBT_ADDR_TIMING   8'h00
`define CBT_ADDR_STATUS   8'h04
`define CBT_ADDR_FILT0    8'h08
`define CBT_ADDR_MASK0    8'h20
`define CBT_ADDR_MASK1    8'h24
`define CBT_ADDR_RX_BUFFER_0     8'h28
`define CBT_ADDR_RX_BUFFER_1     8'h38

// ----------------------------------------------------------------
// timing register fields
// ----------------------------------------------------------------
`define CBT_TIM_PRE_LSB   0
`define CBT_TIM_PRE_MSB   5
`define CBT_TIM_PROP_LSB  6
`define CBT_TIM_PROP_MSB  8
`define CBT_TIM_PS1_LSB   9
`define CBT_TIM_PS1_MSB   11
`define CBT_TIM_PS2_LSB   12
`define CBT_TIM_PS2_MSB   14
`define CBT_TIM_SJW_LSB   15
`define CBT_TIM_SJW_MSB   16
`define CBT_TIM_TRIPLE    17
`define CBT_TIM_RESET     32'h0003_7E40

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define CBT_ST_FULL0      0
`define CBT_ST_FULL1      1
`define CBT_ST_OVF0       2
`define CBT_ST_OVF1       3
`define CBT_ST_RXBIT      4
`define CBT_ST_HIT_LSB    5
`define CBT_ST_HIT_MSB    7

// ----------------------------------------------------------------
// filter, identifier and timing constants
// ----------------------------------------------------------------
`define CBT_FILT_EXT      30
`define CBT_STD_ID_W      11
`define CBT_EXT_ID_W      29
`define CBT_IPT_TQ        3'h2
`define CBT_SYNC_TQ       4'h1

`endif

/* File: verilog/cbt_bit_timing.v */
// nominal bit timing: quantum prescaler, segments, resync, sampling
// assumes bus input synchronous to the clock, config held stable
`timescale 1ns/1ps
`include "cbt_defs.vh"

module cbt_bit_timing #(
  parameter PRE_W = 6
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire [PRE_W-1:0] prescaler_i,
  input  wire [2:0]       prop_i,
  input  wire [2:0]       ps1_i,
  input  wire [2:0]       ps2_i,
  input  wire [1:0]       sjw_i,
  input  wire             triple_i,
  input  wire             bus_i,
  output reg              rx_bit_o,
  output reg              sample_o,
  output reg              bit_start_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_SYNC = 2'h0;
  localparam ST_PROP = 2'h1;
  localparam ST_PS1  = 2'h2;
  localparam ST_PS2  = 2'h3;

  reg [PRE_W-1:0] half_cnt_q;
  reg             second_half_q;
  reg [1:0]       state_q;
  reg [4:0]       seg_cnt_q;
  reg [4:0]       seg_len_q;
  reg [2:0]       samp_q;
  reg             bus_prev_q;

  wire half_tick = (half_cnt_q == prescaler_i);
  wire tq_tick   = half_tick & second_half_q;
  wire edge_fall = bus_prev_q & ~bus_i;
  wire seg_end   = tq_tick & (seg_cnt_q + 5'h01 >= seg_len_q);
  wire [4:0] sjw_q5 = {3'h0, sjw_i} + 5'h01;
  // phase segment 2 never shorter than the processing time
  wire [4:0] ps2_eff = ({2'h0, ps2_i} + 5'h01 < {2'h0, `CBT_IPT_TQ}) ?
                       {2'h0, `CBT_IPT_TQ} : {2'h0, ps2_i} + 5'h01;
  wire [4:0] ps2_left = seg_len_q - seg_cnt_q;

  function [4:0] min5;
    input [4:0] a;
    input [4:0] b;
    begin
      min5 = (a < b) ? a : b;
    end
  endfunction

  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // quantum prescaler: half quantum is prescaler+1 clocks
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_cnt_q    <= {PRE_W{1'b0}};
      second_half_q <= 1'b0;
      samp_q        <= 3'h7;
      bus_prev_q    <= 1'b1;
    end else begin
      bus_prev_q <= bus_i;
      if (half_tick) begin
        half_cnt_q    <= {PRE_W{1'b0}};
        second_half_q <= ~second_half_q;
        samp_q        <= {samp_q[1:0], bus_i};
      end else begin
        half_cnt_q <= half_cnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // segment sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_SYNC;
      seg_cnt_q   <= 5'h00;
      seg_len_q   <= {1'b0, `CBT_SYNC_TQ};
      rx_bit_o    <= 1'b1;
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
    end else begin
      sample_o    <= 1'b0;
      bit_start_o <= 1'b0;
      if (edge_fall && (state_q == ST_PROP || state_q == ST_PS1)) begin
        seg_len_q <= seg_len_q + ((state_q == ST_PS1) ?
                     min5(seg_cnt_q + 5'h01, sjw_q5) : 5'h00);
      end
      if (edge_fall && state_q == ST_PS2 && ps2_left <= sjw_q5) begin
        // early edge: it opens the next bit, sync quantum taken here
        state_q     <= ST_PROP;
        seg_cnt_q   <= 5'h00;
        seg_len_q   <= {2'h0, prop_i} + 5'h01;
        bit_start_o <= 1'b1;
      end else if (edge_fall && state_q == ST_PS2) begin
        seg_len_q <= seg_len_q - sjw_q5;
      end else if (seg_end) begin
        seg_cnt_q <= 5'h00;
        case (state_q)
          ST_SYNC: begin
            state_q   <= ST_PROP;
            seg_len_q <= {2'h0, prop_i} + 5'h01;
          end
          ST_PROP: begin
            state_q   <= ST_PS1;
            seg_len_q <= {2'h0, ps1_i} + 5'h01;
          end
          ST_PS1: begin
            state_q   <= ST_PS2;
            seg_len_q <= ps2_eff;
            sample_o  <= 1'b1;
            rx_bit_o  <= triple_i ? maj3({samp_q[1:0], bus_i}) : bus_i;
          end
          default: begin
            state_q     <= ST_SYNC;
            seg_len_q   <= {1'b0, `CBT_SYNC_TQ};
            bit_start_o <= 1'b1;
          end
        endcase
      end else if (tq_tick) begin
        seg_cnt_q <= seg_cnt_q + 5'h01;
      end
    end
  end

endmodule

/* File: bench/cbt_bus_node.sv */
// far-side bus node: shifts one byte onto the receive line
// assumes go_i is a one-cycle pulse; line idles recessive
`timescale 1ns/1ps
module cbt_bus_node (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire [7:0] bits_i,
  input  wire [7:0] bit_clks_i,
  output reg        can_o
);
  reg [7:0] sh_q;
  reg [3:0] left_q;
  reg [7:0] cnt_q;
  initial begin
    can_o = 1'b1;
    left_q = 4'h0;
  end
  always @(posedge clk_i) begin
    if (go_i) begin
      sh_q <= bits_i;
      left_q <= 4'h8;
      cnt_q <= 8'h00;
    end else if (left_q != 4'h0) begin
      can_o <= sh_q[7];
      if (cnt_q == bit_clks_i - 8'h01) begin
        cnt_q <= 8'h00;
        sh_q <= {sh_q[6:0], 1'b1};
        left_q <= left_q - 4'h1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else begin
      can_o <= 1'b1;
    end
  end
endmodule

/* File: bench/cbt_checker.sv */
// port checker for the acceptance filter and bit timing top
// assumes one clock domain, bound onto cbt_top
`timescale 1ns/1ps
module cbt_checker (
  input wire        REF_CLK_I,
  input wire        RST_N_I,
  input wire [7:0]  ADDR_I,
  input wire        RD_I,
  input wire [31:0] RDATA_O,
  input wire        MSG_VALID_I,
  input wire        RX_BIT_O,
  input wire        SAMPLE_O,
  input wire        BIT_START_O,
  input wire        ACCEPT0_O,
  input wire        ACCEPT1_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_no_msg;
    !MSG_VALID_I ##1 !MSG_VALID_I;
  endsequence
  sequence s_quiet_sample;
    !SAMPLE_O [*2];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_accept_cause: assert property (s_no_msg |=> !ACCEPT0_O && !ACCEPT1_O)
    else $error("accept without message");
  chk_accept_single: assert property (ACCEPT0_O && !$past(MSG_VALID_I) |=> !ACCEPT0_O)
    else $error("accept pulse too long");
  chk_accept_excl: assert property (!(ACCEPT0_O && ACCEPT1_O))
    else $error("both buffers stored");
  chk_hidden_read: assert property (RD_I && ADDR_I == 8'hFC |=> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_sample_gap: assert property (SAMPLE_O |=> !SAMPLE_O [*3])
    else $error("samples too close");
  chk_start_gap: assert property (BIT_START_O |=> !BIT_START_O [*3])
    else $error("bit starts too close");
  chk_start_sample: assert property (BIT_START_O |=> s_quiet_sample)
    else $error("sample too soon after bit start");
  chk_rx_update: assert property ($changed(RX_BIT_O) |-> SAMPLE_O || $past(SAMPLE_O))
    else $error("rx bit changed off sample point");
endmodule
bind cbt_top cbt_checker i_chk (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .MSG_VALID_I(MSG_VALID_I), .RX_BIT_O(RX_BIT_O),
  .SAMPLE_O(SAMPLE_O), .BIT_START_O(BIT_START_O), .ACCEPT0_O(ACCEPT0_O),
  .ACCEPT1_O(ACCEPT1_O)
);

/* File: bench/tb.sv */
// self-checking bench for cbt_top
// assumes cbt_bus_node drives the receive line
`timescale 1ns/1ps
module tb;
  reg          REF_CLK_I;
  reg          RST_N_I;
  reg  [7:0]   ADDR_I;
  reg  [31:0]  WDATA_I;
  reg          WR_I;
  reg          RD_I;
  wire [31:0]  RDATA_O;
  wire         CAN_RX_I;
  reg          MSG_VALID_I;
  reg  [28:0]  MSG_ID_I;
  reg          MSG_EXT_I;
  reg  [3:0]   MSG_DLC_I;
  reg  [63:0]  MSG_DATA_I;
  wire         RX_BIT_O;
  wire         SAMPLE_O;
  wire         BIT_START_O;
  wire         ACCEPT0_O;
  wire         ACCEPT1_O;
  reg          go;
  reg  [31:0]  d;
  int          miscompares;
  int          checks_done;
  int          cyc;
  logic [31:0] tw [6] = '{32'h2400, 32'h2401, 32'h7FC0, 32'h0000, 32'h2402, 32'h14C0};
  logic [31:0] te [6] = '{32'h10, 32'h20, 32'h32, 32'h0A, 32'h30, 32'h14};
  logic [31:0] ts [6] = '{32'h0A, 32'h14, 32'h22, 32'h06, 32'h1E, 32'h10};
  cbt_top i_dut (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CAN_RX_I(CAN_RX_I),
    .MSG_VALID_I(MSG_VALID_I), .MSG_ID_I(MSG_ID_I), .MSG_EXT_I(MSG_EXT_I),
    .MSG_DLC_I(MSG_DLC_I), .MSG_DATA_I(MSG_DATA_I), .RX_BIT_O(RX_BIT_O),
    .SAMPLE_O(SAMPLE_O), .BIT_START_O(BIT_START_O), .ACCEPT0_O(ACCEPT0_O),
    .ACCEPT1_O(ACCEPT1_O)
  );
  cbt_bus_node i_node (
    .clk_i(REF_CLK_I), .go_i(go), .bits_i(8'h0F), .bit_clks_i(8'h10), .can_o(CAN_RX_I)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task test_done;
    begin
      if (miscompares == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done++;
      if (got !== exp) begin
        miscompares++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      WDATA_I <= v;
      WR_I <= 1'b1;
      @(posedge REF_CLK_I);
      WR_I <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge REF_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge REF_CLK_I);
      RD_I <= 1'b0;
      #1;
      d = RDATA_O;
    end
  endtask
  task msg(input [28:0] id, input ext, input a0, input a1);
    begin
      @(posedge REF_CLK_I);
      MSG_VALID_I <= 1'b1;
      MSG_ID_I <= id;
      MSG_EXT_I <= ext;
      MSG_DATA_I <= {35'h0, id};
      @(posedge REF_CLK_I);
      MSG_VALID_I <= 1'b0;
      @(posedge REF_CLK_I);
      #1;
      chk(ACCEPT0_O, a0);
      chk(ACCEPT1_O, a1);
    end
  endtask
  task wt(input s, output int n);
    begin
      n = 0;
      do begin
        @(posedge REF_CLK_I);
        #1;
        n++;
      end while ((s ? SAMPLE_O : BIT_START_O) !== 1'b1 && n < 300);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    begin
      rd(8'h00);
      chk(d, 32'h0003_7E40);
      rd(8'hFC);
      chk(d, 32'h0);
    end
  endtask
  task t_filter;
    begin
      wr(8'h20, 32'h7FF);
      wr(8'h08, 32'h123);
      wr(8'h24, 32'h1FFF_FFFF);
      wr(8'h10, 32'h5ABC_DEF0);
      wr(8'h1C, 32'h055);
      msg(29'h123, 1'b0, 1'b1, 1'b0);
      rd(8'h28);
      chk(d, 32'h123);
      wr(8'h04, 32'hF);
      msg(29'h122, 1'b0, 1'b0, 1'b0);
      msg(29'h123, 1'b1, 1'b0, 1'b0);
      msg(29'h1ABC_DEF0, 1'b1, 1'b0, 1'b1);
      rd(8'h38);
      chk(d, 32'h5ABC_DEF0);
      wr(8'h04, 32'hF);
      msg(29'h055, 1'b0, 1'b0, 1'b1);
      wr(8'h20, 32'h7FE);
      msg(29'h001, 1'b0, 1'b1, 1'b0);
      wr(8'h04, 32'hF);
      msg(29'h122, 1'b0, 1'b1, 1'b0);
      msg(29'h123, 1'b0, 1'b0, 1'b0);
      rd(8'h04);
      chk(d & 32'h5, 32'h5);
    end
  endtask
  task t_timing;
    int i;
    int n;
    begin
      for (i = 0; i < 6; i++) begin
        wr(8'h00, tw[i]);
        wt(1'b0, n);
        wt(1'b0, n);
        wt(1'b0, n);
        chk(n, te[i]);
        wt(1'b1, n);
        chk(n, ts[i]);
      end
    end
  endtask
  task t_rx;
    int n;
    begin
      wr(8'h00, 32'h2_2400);
      @(posedge REF_CLK_I);
      go <= 1'b1;
      @(posedge REF_CLK_I);
      go <= 1'b0;
      repeat (24) @(posedge REF_CLK_I);
      wt(1'b1, n);
      @(posedge REF_CLK_I);
      #1;
      chk(RX_BIT_O, 1'b0);
      repeat (100) @(posedge REF_CLK_I);
      wt(1'b1, n);
      @(posedge REF_CLK_I);
      #1;
      chk(RX_BIT_O, 1'b1);
    end
  endtask
  // ----------------------------------------
  // clock, reset, sequence, timeout
  // ----------------------------------------
  initial begin
    REF_CLK_I = 1'b0;
    forever #10 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    miscompares = 0;
    checks_done = 0;
    cyc = 0;
    RST_N_I = 1'b0;
    ADDR_I = 8'h00;
    WDATA_I = 32'h0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    MSG_VALID_I = 1'b0;
    MSG_ID_I = 29'h0;
    MSG_EXT_I = 1'b0;
    MSG_DLC_I = 4'h8;
    MSG_DATA_I = 64'h0;
    go = 1'b0;
    repeat (8) @(posedge REF_CLK_I);
    RST_N_I <= 1'b1;
    t_regs;
    t_filter;
    t_timing;
    t_rx;
    test_done;
  end
endmodule
